/* File: sfm_pkg.sv */
package sfm_pkg;
   localparam int REG_CNT = 28;
   localparam int EXT_CNT = 8;
   localparam int REG_W = 40;
   localparam int INT_W = 32;
   localparam int CNT_W = 7;
   localparam int IDX_W = 5;
   localparam int FLG_W = 7;
   localparam int F_LUF = 6;
   localparam int F_LV = 5;
   localparam int F_UF = 4;
   localparam int F_N = 3;
   localparam int F_Z = 2;
   localparam int F_V = 1;
   localparam int F_C = 0;
   localparam logic [7:0] EXP_ZERO = 8'h80;
   localparam logic [7:0] EXP_MAX = 8'h7f;
   localparam logic [FLG_W-1:0] FLG_RST = 7'h00;
   localparam logic [REG_W-1:0] REG_RST = 40'h0000000000;
   localparam logic [1:0] G_REG = 2'h0;
   localparam logic [1:0] G_DIR = 2'h1;
   localparam logic [1:0] G_IND = 2'h2;
   localparam logic [1:0] G_IMM = 2'h3;
   typedef enum logic [1:0] {
      OP_SHIFT = 2'b00,
      OP_SHIFT_STORE = 2'b01,
      OP_FMUL2 = 2'b10,
      OP_FMUL3 = 2'b11
   } sfm_op_e;
endpackage : sfm_pkg

/* File: sfm_shift_if.sv */
`timescale 1ns/1ps
interface sfm_shift_if;
   logic [31:0] src;
   logic [6:0] cnt;
   logic [31:0] res;
   logic carry;
   modport drv (output src, output cnt, input res, input carry);
   modport shf (input src, input cnt, output res, output carry);
endinterface : sfm_shift_if

/* File: sfm_shift.sv */
`timescale 1ns/1ps
module sfm_shift (
   sfm_shift_if.shf io
);
   logic [6:0] mag;
   logic [64:0] lft;
   logic [32:0] rgt;

   // magnitude of a 7-bit count, -64 gives 64 which still fits
   assign mag = io.cnt[6] ? (~io.cnt + 7'h01) : io.cnt;
   // wide shifts so 32 or more empties the word; carry is the last bit out, zeros only past 32
   assign lft = {33'h0, io.src} << mag;
   assign rgt = {io.src, 1'b0} >> mag;

   always_comb begin
      if (io.cnt == 7'h00) begin
         io.res = io.src;
         io.carry = 1'b0;
      end else if (!io.cnt[6]) begin
         io.res = lft[31:0];
         io.carry = lft[32];
      end else begin
         io.res = rgt[32:1];
         io.carry = rgt[0];
      end
   end
endmodule : sfm_shift

/* File: sfm_exec.sv */
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module sfm_exec (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic OP_VALID_I,
   input wire sfm_pkg::sfm_op_e OP_CODE_I,
   input wire logic [1:0] MODE_I,
   input wire logic [4:0] DST_I,
   input wire logic [4:0] SRC1_I,
   input wire logic [4:0] SRC2_I,
   input wire logic [2:0] STORE_SRC_I,
   input wire logic [31:0] MEM_A_I,
   input wire logic [31:0] MEM_B_I,
   input wire logic [31:0] IMM_I,
   input wire logic OVF_SAT_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [4:0] REG_IDX_I,
   input wire logic [39:0] REG_WDATA_I,
   output logic [39:0] REG_RDATA_O,
   output logic [6:0] FLAGS_O,
   output logic [39:0] RESULT_O,
   output logic STORE_VALID_O,
   output logic [31:0] STORE_DATA_O
);
   typedef struct packed {
      logic [sfm_pkg::REG_CNT-1:0][sfm_pkg::REG_W-1:0] regs;
      logic [sfm_pkg::FLG_W-1:0] flags;
      logic [sfm_pkg::REG_W-1:0] result;
      logic [sfm_pkg::REG_W-1:0] rdata;
      logic st_valid;
      logic [sfm_pkg::INT_W-1:0] st_data;
   } sfm_state_s;

   sfm_state_s state_r;
   sfm_state_s state_nxt;

   sfm_shift_if sh ();

   sfm_shift u_shift (
      .io(sh.shf)
   );

   logic [4:0] s1_idx;
   logic [4:0] s2_idx;
   logic [4:0] d_idx;
   logic [39:0] rv1;
   logic [39:0] rv2;
   logic [39:0] rdst;
   logic [31:0] st_pre;
   logic [31:0] mul_b;
   logic [39:0] mul_a;
   logic [41:0] mul_out;
   logic is_shift;
   logic is_mul;
   logic ext_dst;
   logic dst_ok;

   function automatic logic [39:0] rd_reg(input sfm_state_s s, input logic [4:0] idx);
      logic [39:0] v;
      v = 40'h0000000000;
      if (idx < 5'(sfm_pkg::REG_CNT)) begin
         v = s.regs[idx];
      end
      return v;
   endfunction : rd_reg

   // extended word keeps exponent on top, sign at bit 31, 31 mantissa bits
   function automatic logic [31:0] to_single(input logic [39:0] e);
      return {e[39:32], e[31], e[30:8]};
   endfunction : to_single

   function automatic logic [39:0] to_ext(input logic [31:0] s);
      return {s[31:24], s[23], s[22:0], 8'h00};
   endfunction : to_ext

   // returns {underflow, overflow, product}
   function automatic logic [41:0] fmul(input logic [39:0] a, input logic [31:0] b);
      logic [31:0] ma;
      logic [23:0] mb;
      logic [55:0] p;
      logic [30:0] mant;
      logic signed [9:0] e;
      logic sgn;
      logic [41:0] r;
      ma = {1'b1, a[30:0]};
      mb = {1'b1, b[22:0]};
      p = 56'(ma) * 56'(mb);
      sgn = a[31] ^ b[23];
      e = 10'(signed'(a[39:32])) + 10'(signed'(b[31:24]));
      if (p[55]) begin
         mant = p[54:24];
         e = e + 10'sd1;
      end else begin
         mant = p[53:23];
      end
      if (a[39:32] == sfm_pkg::EXP_ZERO || b[31:24] == sfm_pkg::EXP_ZERO) begin
         r = {2'b00, sfm_pkg::EXP_ZERO, 32'h00000000};
      end else if (e > 10'sd127) begin
         r = {2'b01, sfm_pkg::EXP_MAX, sgn, 31'h7fffffff};
      end else if (e < -10'sd127) begin
         r = {2'b10, sfm_pkg::EXP_ZERO, 32'h00000000};
      end else begin
         r = {2'b00, e[7:0], sgn, mant};
      end
      return r;
   endfunction : fmul

   assign is_shift = OP_VALID_I &&
                     (OP_CODE_I == sfm_pkg::OP_SHIFT || OP_CODE_I == sfm_pkg::OP_SHIFT_STORE);
   assign is_mul = OP_VALID_I &&
                   (OP_CODE_I == sfm_pkg::OP_FMUL2 || OP_CODE_I == sfm_pkg::OP_FMUL3);

   // standalone shift reaches all 28 registers, the other forms only 0-7
   always_comb begin
      if (OP_CODE_I == sfm_pkg::OP_SHIFT) begin
         s1_idx = SRC1_I;
         s2_idx = SRC2_I;
         d_idx = DST_I;
      end else begin
         s1_idx = {2'b00, SRC1_I[2:0]};
         s2_idx = {2'b00, SRC2_I[2:0]};
         d_idx = {2'b00, DST_I[2:0]};
      end
   end

   // all register operands come from the registered state, results land at the edge
   assign rv1 = rd_reg(state_r, s1_idx);
   assign rv2 = rd_reg(state_r, s2_idx);
   assign rdst = rd_reg(state_r, d_idx);
   assign st_pre = state_r.regs[STORE_SRC_I][31:0];
   assign dst_ok = d_idx < 5'(sfm_pkg::REG_CNT);
   assign ext_dst = d_idx < 5'(sfm_pkg::EXT_CNT);

   always_comb begin
      if (OP_CODE_I == sfm_pkg::OP_SHIFT) begin
         sh.src = MODE_I[0] ? MEM_A_I : rv1[31:0];
         sh.cnt = MODE_I[1] ? MEM_B_I[6:0] : rv2[6:0];
      end else begin
         sh.src = rv1[31:0];
         sh.cnt = rv2[6:0];
      end
   end

   always_comb begin
      if (OP_CODE_I == sfm_pkg::OP_FMUL2) begin
         mul_a = rdst;
         case (MODE_I)
            sfm_pkg::G_REG: mul_b = to_single(rv1);
            sfm_pkg::G_DIR: mul_b = MEM_A_I;
            sfm_pkg::G_IND: mul_b = MEM_A_I;
            sfm_pkg::G_IMM: mul_b = IMM_I;
            default: mul_b = IMM_I;
         endcase
      end else begin
         mul_a = MODE_I[0] ? to_ext(MEM_A_I) : to_ext(to_single(rv1));
         mul_b = MODE_I[1] ? MEM_B_I : to_single(rv2);
      end
   end

   assign mul_out = fmul(mul_a, mul_b);

   // the saturate setting is deliberately not looked at by any path here
   always_comb begin
      state_nxt = state_r;
      state_nxt.st_valid = 1'b0;
      state_nxt.rdata = REG_RDATA_O;
      if (REG_RD_I) begin
         state_nxt.rdata = rd_reg(state_r, REG_IDX_I);
      end
      if (REG_WR_I && REG_IDX_I < 5'(sfm_pkg::REG_CNT)) begin
         state_nxt.regs[REG_IDX_I] = REG_WDATA_I;
      end
      // execute result overrides a software write to the same register
      if (is_shift && dst_ok) begin
         state_nxt.regs[d_idx] = {rdst[39:32], sh.res};
         state_nxt.result = {rdst[39:32], sh.res};
         if (ext_dst) begin
            state_nxt.flags[sfm_pkg::F_UF] = 1'b0;
            state_nxt.flags[sfm_pkg::F_V] = 1'b0;
            state_nxt.flags[sfm_pkg::F_N] = sh.res[31];
            state_nxt.flags[sfm_pkg::F_Z] = sh.res == 32'h00000000;
            state_nxt.flags[sfm_pkg::F_C] = sh.carry;
         end
      end
      if (OP_VALID_I && OP_CODE_I == sfm_pkg::OP_SHIFT_STORE) begin
         // read data of this cycle is already consumed before the store leaves
         state_nxt.st_valid = 1'b1;
         state_nxt.st_data = st_pre;
      end
      if (is_mul) begin
         state_nxt.regs[d_idx] = mul_out[39:0];
         state_nxt.result = mul_out[39:0];
         if (ext_dst) begin
            state_nxt.flags[sfm_pkg::F_UF] = mul_out[41];
            state_nxt.flags[sfm_pkg::F_LUF] = state_r.flags[sfm_pkg::F_LUF] | mul_out[41];
            state_nxt.flags[sfm_pkg::F_V] = mul_out[40];
            state_nxt.flags[sfm_pkg::F_LV] = state_r.flags[sfm_pkg::F_LV] | mul_out[40];
            state_nxt.flags[sfm_pkg::F_N] = mul_out[31];
            state_nxt.flags[sfm_pkg::F_Z] = mul_out[39:32] == sfm_pkg::EXP_ZERO;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_r.regs <= {sfm_pkg::REG_CNT{sfm_pkg::REG_RST}};
         state_r.flags <= sfm_pkg::FLG_RST;
         state_r.result <= sfm_pkg::REG_RST;
         state_r.rdata <= sfm_pkg::REG_RST;
         state_r.st_valid <= 1'b0;
         state_r.st_data <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign REG_RDATA_O = state_r.rdata;
   assign FLAGS_O = state_r.flags;
   assign RESULT_O = state_r.result;
   assign STORE_VALID_O = state_r.st_valid;
   assign STORE_DATA_O = state_r.st_data;

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RST_I);

   logic sh_src31;
   logic [31:0] sh_res_q;
   assign sh_src31 = sh.src[31];
   assign sh_res_q = sh.res;

   sequence s_shift_ext;
      is_shift && dst_ok && ext_dst;
   endsequence

   sequence s_store_issue;
      OP_VALID_I && OP_CODE_I == sfm_pkg::OP_SHIFT_STORE;
   endsequence

   sequence s_mul_ext;
      is_mul && ext_dst;
   endsequence

   flags_guard_a: assert property (
      OP_VALID_I && !ext_dst |=> $stable(FLAGS_O))
      else $error("flags changed for a non-extended destination");

   shift_zero_a: assert property (
      s_shift_ext ##0 sh.cnt == 7'h00 |=> !FLAGS_O[sfm_pkg::F_C] &&
         RESULT_O[31:0] == $past(sh.src))
      else $error("zero count did not pass source or clear carry");

   shift_flags_a: assert property (
      s_shift_ext |=> !FLAGS_O[sfm_pkg::F_UF] && !FLAGS_O[sfm_pkg::F_V] &&
         FLAGS_O[sfm_pkg::F_N] == RESULT_O[31] &&
         FLAGS_O[sfm_pkg::F_Z] == (RESULT_O[31:0] == 32'h00000000) &&
         $stable(FLAGS_O[sfm_pkg::F_LV]) && $stable(FLAGS_O[sfm_pkg::F_LUF]))
      else $error("shift flags wrong");

   carry_left_a: assert property (
      s_shift_ext ##0 sh.cnt == 7'h01 |=> FLAGS_O[sfm_pkg::F_C] == $past(sh_src31))
      else $error("carry is not the bit shifted out");

   right_fill_a: assert property (
      s_shift_ext ##0 sh.cnt == 7'h7f |=> !RESULT_O[31])
      else $error("right shift copied the sign");

   store_pre_a: assert property (
      s_store_issue |=> STORE_VALID_O && STORE_DATA_O == $past(st_pre) ##1 !STORE_VALID_O ||
         $past(OP_VALID_I))
      else $error("store did not use the old register value");

   mul_uf_a: assert property (
      s_mul_ext ##0 mul_out[41] |=> FLAGS_O[sfm_pkg::F_UF] && FLAGS_O[sfm_pkg::F_LUF])
      else $error("underflow flags not set");

   mul_sticky_a: assert property (
      s_mul_ext ##0 !mul_out[41] |=> !FLAGS_O[sfm_pkg::F_UF] &&
         $stable(FLAGS_O[sfm_pkg::F_LUF]))
      else $error("latched underflow changed without underflow");

   mul_carry_a: assert property (
      s_mul_ext |=> $stable(FLAGS_O[sfm_pkg::F_C]) &&
         FLAGS_O[sfm_pkg::F_V] == $past(mul_out[40]))
      else $error("multiply touched carry or overflow wrong");

   one_cycle_a: assert property (
      is_shift && dst_ok |=> RESULT_O[31:0] == $past(sh_res_q))
      else $error("shift result not written in one cycle");

   // spot checks at chosen counts; the bench tries a table of 11 counts plus random ones
   right_carry_a: assert property (
      s_shift_ext ##0 sh.cnt == 7'h7f |=> FLAGS_O[sfm_pkg::F_C] == $past(sh.src[0]) &&
         RESULT_O[31:0] == {1'b0, $past(sh.src[31:1])})
      else $error("right shift by one wrong");

   left_fill_a: assert property (
      s_shift_ext ##0 sh.cnt == 7'h01 |=> RESULT_O[31:0] == {$past(sh.src[30:0]), 1'b0})
      else $error("left shift by one wrong");

   wide_shift_a: assert property (
      s_shift_ext ##0 sh.cnt == 7'h20 |=> RESULT_O[31:0] == 32'h00000000 &&
         FLAGS_O[sfm_pkg::F_C] == $past(sh.src[0]))
      else $error("shift by 32 did not empty the word");

   count_low_a: assert property (
      is_shift && dst_ok ##0 sh.cnt == 7'h60 |=> RESULT_O[31:0] == 32'h00000000)
      else $error("count of minus 32 not taken as a right shift");

   mul_ov_a: assert property (
      s_mul_ext ##0 mul_out[40] |=> FLAGS_O[sfm_pkg::F_V] && FLAGS_O[sfm_pkg::F_LV])
      else $error("overflow flags not set");

   mul_lv_keep_a: assert property (
      s_mul_ext ##0 !mul_out[40] |=> $stable(FLAGS_O[sfm_pkg::F_LV]))
      else $error("latched overflow changed without overflow");

   mul_nz_a: assert property (
      s_mul_ext |=> FLAGS_O[sfm_pkg::F_N] == RESULT_O[31] &&
         FLAGS_O[sfm_pkg::F_Z] == (RESULT_O[39:32] == sfm_pkg::EXP_ZERO))
      else $error("multiply sign or zero flag wrong");

   // a stray pulse would corrupt memory, so quiet cycles are watched too
   store_quiet_a: assert property (
      !(OP_VALID_I && OP_CODE_I == sfm_pkg::OP_SHIFT_STORE) |=> !STORE_VALID_O)
      else $error("store pulse without a parallel store");

   shift_write_a: assert property (
      is_shift && dst_ok |=> state_r.regs[$past(d_idx)][31:0] == $past(sh_res_q))
      else $error("shift result not in the register file");

   mul_write_a: assert property (
      is_mul |=> state_r.regs[$past(d_idx)] == $past(mul_out[39:0]))
      else $error("product not in the register file");
endmodule : sfm_exec

/* File: sfm_mem_model.sv */
`timescale 1ns/1ps
module sfm_mem_model (
   input wire logic clk_i,
   input wire logic [3:0] a_adr_i,
   input wire logic [3:0] b_adr_i,
   input wire logic [3:0] st_adr_i,
   input wire logic st_vld_i,
   input wire logic [31:0] st_dat_i,
   output logic [31:0] a_dat_o,
   output logic [31:0] b_dat_o
);
   logic [31:0] mem [16];
   logic [3:0] st_adr_r;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 32'h01234567 * i;
      end
   end
   // operands are read this cycle; the store lands one edge later, so a read wins
   assign a_dat_o = mem[a_adr_i];
   assign b_dat_o = mem[b_adr_i];
   always @(posedge clk_i) begin
      st_adr_r <= st_adr_i;
      if (st_vld_i === 1'b1) begin
         mem[st_adr_r] <= st_dat_i;
      end
   end
endmodule : sfm_mem_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [6:0] f; logic [7:0] e; logic [31:0] r; logic cr; logic sv;
      logic [31:0] sd;} sfm_note_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic opv = 1'b0;
   logic ovf = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   sfm_pkg::sfm_op_e code = sfm_pkg::OP_SHIFT;
   logic [1:0] mode = 2'h0;
   logic [4:0] dst = 5'h0;
   logic [4:0] s1 = 5'h0;
   logic [4:0] s2 = 5'h0;
   logic [4:0] idx = 5'h0;
   logic [2:0] ss = 3'h0;
   logic [31:0] imm = 32'h0;
   logic [39:0] wd = 40'h0;
   logic [3:0] aa = 4'h0;
   logic [3:0] ba = 4'h0;
   logic [3:0] sa = 4'h0;
   logic [31:0] ma, mb, sd;
   logic [39:0] rdat, res;
   logic [6:0] flg;
   logic sv;
   logic [39:0] regs [28];
   logic [31:0] tm [16];
   logic [6:0] ef = 7'h00;
   sfm_note_s nq[$];
   logic [39:0] rq[$];
   logic opd = 1'b0;
   logic rdd = 1'b0;
   logic pend = 1'b0;
   logic [3:0] pa;
   logic [31:0] pdat;
   int err_total = 0;
   int tests_run = 0;
   logic [31:0] seed = 32'h34;
   logic [6:0] cnt_tab [11] = '{7'h00, 7'h01, 7'h1f, 7'h20, 7'h21, 7'h3f, 7'h7f, 7'h61,
      7'h60, 7'h5f, 7'h40};

   sfm_exec dut (.CORE_CLK_I(clk), .RST_I(rst), .OP_VALID_I(opv), .OP_CODE_I(code),
      .MODE_I(mode), .DST_I(dst), .SRC1_I(s1), .SRC2_I(s2), .STORE_SRC_I(ss),
      .MEM_A_I(ma), .MEM_B_I(mb), .IMM_I(imm), .OVF_SAT_I(ovf), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_IDX_I(idx), .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .FLAGS_O(flg),
      .RESULT_O(res), .STORE_VALID_O(sv), .STORE_DATA_O(sd));
   sfm_mem_model mem_u (.clk_i(clk), .a_adr_i(aa), .b_adr_i(ba), .st_adr_i(sa),
      .st_vld_i(sv), .st_dat_i(sd), .a_dat_o(ma), .b_dat_o(mb));

   always #2.5 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic cmp(input logic [39:0] g, input logic [39:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp

   task automatic cmp_rd(input logic [39:0] g, input logic [39:0] e);
      cmp(g, e);
   endtask : cmp_rd

   task automatic cmp_flg(input logic [6:0] g, input logic [6:0] e);
      cmp(40'(g), 40'(e));
   endtask : cmp_flg

   task automatic cmp_res(input logic [39:0] g, input logic [39:0] e);
      cmp(g, e);
   endtask : cmp_res

   task automatic cmp_st(input logic [31:0] g, input logic [31:0] e);
      cmp(40'(g), 40'(e));
   endtask : cmp_st

   task automatic finish_test();
      if (err_total == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   // every strobe is set once per edge; a store seen last cycle reaches the mirror now
   task automatic put(input logic w, input logic r, input logic o);
      @(posedge clk);
      wr <= w;
      rd <= r;
      opv <= o;
      ovf <= ^rnd();
      if (pend) tm[pa] = pdat;
      pend = 1'b0;
   endtask : put

   task automatic reg_wr(input logic [4:0] i, input logic [39:0] d);
      put(1'b0 | 1'b1, 1'b0, 1'b0);
      idx <= i;
      wd <= d;
      if (i < 5'd28) regs[i] = d;
   endtask : reg_wr

   task automatic reg_rd(input logic [4:0] i);
      put(1'b0, 1'b1, 1'b0);
      idx <= i;
      rq.push_back(i < 5'd28 ? regs[i] : 40'h0);
   endtask : reg_rd

   task automatic exec(input sfm_pkg::sfm_op_e c, input logic [1:0] m, input logic [4:0] d,
         input logic [4:0] a, input logic [4:0] b, input logic [2:0] s, input logic [3:0] x,
         input logic [3:0] y, input logic [31:0] im, input logic [3:0] fe,
         input logic [39:0] mr, input logic mc);
      logic [31:0] sr;
      logic [6:0] k;
      logic [63:0] v;
      logic [3:0] st;
      logic cy;
      sfm_note_s n;
      sr = m[0] ? tm[x] : regs[a][31:0];
      k = m[1] ? tm[y][6:0] : regs[b][6:0];
      st = 4'(rnd());
      if (!k[6]) begin
         v = {32'h0, sr} << k;
         n.r = v[31:0];
         cy = v[32];
      end else begin
         v = {sr, 32'h0} >> (7'h0 - k);
         n.r = v[63:32];
         cy = v[31];
      end
      n.sv = (c == sfm_pkg::OP_SHIFT_STORE);
      n.sd = regs[s][31:0];
      n.cr = (d < 5'd28);
      n.e = c[1] ? mr[39:32] : regs[d][39:32];
      if (c[1]) begin
         n.r = mr[31:0];
         n.cr = mc;
         ef = {ef[6] | fe[3], ef[5] | fe[0], fe, ef[0]};
         if (mc) regs[d] = mr;
      end else begin
         if (d < 5'd8) ef = {ef[6:5], 1'b0, n.r[31], n.r == 32'h0, 1'b0, cy};
         if (n.cr) regs[d][31:0] = n.r;
      end
      n.f = ef;
      put(1'b0, 1'b0, 1'b1);
      code <= c;
      mode <= m;
      dst <= d;
      s1 <= a;
      s2 <= b;
      ss <= s;
      aa <= x;
      ba <= y;
      sa <= st;
      imm <= im;
      pend = n.sv;
      pa = st;
      pdat = n.sd;
      nq.push_back(n);
   endtask : exec

   always @(posedge clk) begin
      opd <= opv;
      rdd <= rd;
   end

   always @(negedge clk) begin
      sfm_note_s n;
      if (rdd) cmp_rd(rdat, rq.pop_front());
      if (opd) begin
         n = nq.pop_front();
         cmp_flg(flg, n.f);
         if (n.cr) cmp_res(res, {n.e, n.r});
         cmp_st(32'(sv), 32'(n.sv));
         if (n.sv) cmp_st(sd, n.sd);
      end else begin
         cmp_st(32'(sv), 32'h0);
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      finish_test();
   end

   initial begin
      logic [4:0] a5, b5;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++) tm[i] = mem_u.mem[i];
      for (int i = 0; i < 28; i++) regs[i] = 40'h0;
      reg_rd(5'd5);
      // overflow then underflow, then plain products must keep both latched flags
      reg_wr(5'd1, 40'h7f00000000);
      exec(sfm_pkg::OP_FMUL2, sfm_pkg::G_IMM, 5'd1, 5'd1, 5'd0, 3'd0, 4'd0, 4'd0,
         32'h7f000000, 4'b0001, 40'h0, 1'b0);
      reg_wr(5'd1, 40'h8100000000);
      exec(sfm_pkg::OP_FMUL2, sfm_pkg::G_IMM, 5'd1, 5'd1, 5'd0, 3'd0, 4'd0, 4'd0,
         32'h81000000, 4'b1010, 40'h8000000000, 1'b1);
      reg_wr(5'd1, 40'h0);
      reg_wr(5'd2, 40'h0);
      for (int m = 0; m < 4; m++) begin
         exec(sfm_pkg::OP_FMUL2, 2'(m), 5'd1, 5'd2, 5'd0, 3'd0, 4'd0, 4'd0, 32'h0, 4'h0,
            40'h0, 1'b1);
         exec(sfm_pkg::OP_FMUL3, 2'(m), 5'd3, 5'd1, 5'd2, 3'd0, 4'd0, 4'd0, 32'h0, 4'h0,
            40'h0, 1'b1);
      end
      for (int i = 0; i < 28; i++) reg_wr(5'(i), {8'(rnd()), rnd()});
      reg_wr(5'd30, 40'hff00ff00ff);
      for (int i = 0; i < 32; i++) reg_rd(5'(i));
      reg_wr(5'd10, 40'h5a80000001);
      foreach (cnt_tab[j]) begin
         reg_wr(5'd11, {33'(rnd()), cnt_tab[j]});
         exec(sfm_pkg::OP_SHIFT, 2'b00, 5'(j % 10), 5'd10, 5'd11, 3'd0, 4'd0, 4'd0, 32'h0,
            4'h0, 40'h0, 1'b0);
      end
      for (int i = 0; i < 80; i++) begin
         a5 = 5'(rnd() % 28);
         b5 = 5'(rnd() % 28);
         if (i % 3 == 0) exec(sfm_pkg::OP_SHIFT_STORE, 2'b00, 5'(a5 % 8), 5'(b5 % 8),
            5'(a5 % 5), 3'(rnd()), 4'(rnd()), 4'(rnd()), 32'h0, 4'h0, 40'h0, 1'b0);
         else exec(sfm_pkg::OP_SHIFT, 2'(rnd()), 5'(rnd()), a5, b5, 3'(rnd()), 4'(rnd()),
            4'(rnd()), 32'h0, 4'h0, 40'h0, 1'b0);
      end
      for (int i = 0; i < 28; i++) reg_rd(5'(i));
      put(1'b0, 1'b0, 1'b0);
      put(1'b0, 1'b0, 1'b0);
      put(1'b0, 1'b0, 1'b0);
      finish_test();
   end
endmodule : tb_top
